// ---- verilog/oscdc_params.svh ----
// Constants for the oscillator divider control block: offsets, fields, resets.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef OSCDC_PARAMS_SVH
`define OSCDC_PARAMS_SVH

// Register word address on the plain register port.
`define OSCDC_ADDR_CTRL 4'h0
`define OSCDC_ADDR_UNLOCK 4'h1
// Unlock keys written in order to the unlock address.
`define OSCDC_KEY1 32'haa996655
`define OSCDC_KEY2 32'h556699aa
// Field positions in the control word.
`define OSCDC_PLL_OUT_DIV_HI 29
`define OSCDC_PLL_OUT_DIV_LO 27
`define OSCDC_FAST_RC_DIV_HI 26
`define OSCDC_FAST_RC_DIV_LO 24
`define OSCDC_SOSC_READY_BIT 22
`define OSCDC_PBRDY_BIT 21
`define OSCDC_PB_DIV_HI 20
`define OSCDC_PB_DIV_LO 19
`define OSCDC_PLLMUL_HI 18
`define OSCDC_PLLMUL_LO 16
`define OSCDC_NEW_SRC_HI 10
`define OSCDC_NEW_SRC_LO 8
`define OSCDC_SOSC_EN_BIT 1
// Reset value of the fast RC divider (divide by two).
`define OSCDC_FAST_RC_DIV_RST 3'h1
// Peripheral divisor held under reset until configuration is loaded (divide by eight).
`define OSCDC_PB_DIV_RST 2'h3
// Secondary oscillator warm-up time in ns and its cycle count at 4 ns.
`define OSCDC_CLK_NS 4
`define OSCDC_SOSC_WARM_NS 1000
`define OSCDC_SOSC_WARM_CYC ((`OSCDC_SOSC_WARM_NS + `OSCDC_CLK_NS - 1) / `OSCDC_CLK_NS)

`endif

// ---- verilog/oscdc_pkg.sv ----
// Types for the oscillator divider control block.
// Assumes oscdc_params.svh is on the include path.
`include "oscdc_params.svh"

package oscdc_pkg;
   // Register bus request.
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } oscdc_req_s;

   // Configuration word loaded at the first clock edge after each reset release.
   typedef struct packed {
      logic [2:0] pll_out_divider;
      logic [1:0] periph_clock_divisor;
      logic [2:0] pll_multiplier;
      logic [2:0] new_source_select;
      logic secondary_osc_enable;
   } oscdc_cfg_s;

   // Unlock sequence states, Gray coded.
   typedef enum logic [1:0] {
      OSCDC_LOCKED = 2'h0,
      OSCDC_KEY1_OK = 2'h1,
      OSCDC_OPEN = 2'h3
   } oscdc_unlock_e;
endpackage : oscdc_pkg

// ---- verilog/oscdc_pow2_div.sv ----
// Power-of-two clock enable divider with glitch-free ratio change.
// Assumes one clock domain; the tick pulses one cycle in every 2^shift.
module oscdc_pow2_div #(
   parameter int SW = 4
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Ratio control.
   input wire logic [SW-1:0] shift,
   // Divided tick and settle status.
   output logic tick,
   output logic settled
);
   logic [8:0] cnt_r;
   logic [SW-1:0] act_r;
   logic [8:0] lim;

   assign lim = 9'((9'h1 << act_r) - 9'h1);
   assign tick = (cnt_r == lim);
   assign settled = (act_r == shift);

   // Ratio changes only at a period boundary, so no short tick is produced.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 9'h0;
         act_r <= '0;
      end else if (tick) begin
         cnt_r <= 9'h0;
         act_r <= shift;
      end else begin
         cnt_r <= 9'(cnt_r + 9'h1);
      end
   end
endmodule : oscdc_pow2_div

// ---- verilog/oscdc_sosc_mon.sv ----
// Secondary oscillator warm-up monitor.
// Assumes the oscillator runs whenever the enable is high.
`include "oscdc_params.svh"

module oscdc_sosc_mon #(
   parameter int WARM = `OSCDC_SOSC_WARM_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Enable and ready.
   input wire logic enable,
   output logic ready
);
   logic [15:0] cnt_r;

   // Counter restarts whenever the oscillator is turned off.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 16'h0;
      end else if (!enable) begin
         cnt_r <= 16'h0;
      end else if (cnt_r != 16'(WARM)) begin
         cnt_r <= 16'(cnt_r + 16'h1);
      end
   end

   assign ready = enable && (cnt_r == 16'(WARM));
endmodule : oscdc_sosc_mon

// ---- verilog/oscdc_ctrl.sv ----
// Oscillator divider control register with unlock guard and divider ticks.
// Assumes the register port master of the group and a configuration word
// that is stable from reset release on.
//
// The placing of the registers and the plain strobed port were decided locally.
`include "oscdc_params.svh"

module oscdc_ctrl #(
   parameter int SOSC_WARM = `OSCDC_SOSC_WARM_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Configuration bits.
   input wire oscdc_pkg::oscdc_cfg_s cfg,
   // Divided clock enables.
   output logic pll_div_tick,
   output logic fast_rc_div_tick,
   output logic periph_bus_clock_tick,
   // Current field values.
   output logic [2:0] pll_multiplier,
   output logic [2:0] new_source_select,
   output logic secondary_osc_enable
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   oscdc_pkg::oscdc_unlock_e lock_r;
   logic [2:0] pll_out_divider_r;
   logic [2:0] fast_rc_divider_r;
   logic [1:0] periph_clock_divisor_r;
   logic [2:0] pll_multiplier_r;
   logic [2:0] new_source_select_r;
   logic secondary_osc_enable_r;
   logic cfg_loaded_r;
   logic ctrl_wr;
   logic secondary_osc_ready;
   logic periph_divisor_ready;
   logic pb_settled;
   logic [3:0] pll_shift;
   logic [3:0] fast_rc_shift;
   logic [1:0] wr_pb_field;
   logic [3:0] pb_shift;
   logic [31:0] rd_word;

   // Maps a three-bit divider code to a shift; code 111 skips to 256.
   function automatic logic [3:0] code_shift(input logic [2:0] c);
      code_shift = (c == 3'h7) ? 4'h8 : {1'b0, c};
   endfunction : code_shift

   // ****************************************************************
   // Unlock sequence
   // ****************************************************************
   // Two keys open the register for exactly one write, then it relocks.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lock_r <= oscdc_pkg::OSCDC_LOCKED;
      end else if (reg_wr && reg_addr == `OSCDC_ADDR_UNLOCK) begin
         if (reg_wdata == `OSCDC_KEY1) begin
            lock_r <= oscdc_pkg::OSCDC_KEY1_OK;
         end else if (reg_wdata == `OSCDC_KEY2 && lock_r == oscdc_pkg::OSCDC_KEY1_OK) begin
            lock_r <= oscdc_pkg::OSCDC_OPEN;
         end else begin
            lock_r <= oscdc_pkg::OSCDC_LOCKED;
         end
      end else if (reg_wr) begin
         lock_r <= oscdc_pkg::OSCDC_LOCKED;
      end
   end

   assign ctrl_wr = reg_wr && reg_addr == `OSCDC_ADDR_CTRL &&
                    lock_r == oscdc_pkg::OSCDC_OPEN;

   // ****************************************************************
   // Control fields
   // ****************************************************************
   // The first edge after release loads the configured fields; a strap read
   // under asynchronous reset would be illegal, so it waits for the clock.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_loaded_r <= 1'b0;
         pll_out_divider_r <= 3'h0;
         fast_rc_divider_r <= `OSCDC_FAST_RC_DIV_RST;
         pll_multiplier_r <= 3'h0;
         new_source_select_r <= 3'h0;
         secondary_osc_enable_r <= 1'b0;
      end else if (!cfg_loaded_r) begin
         cfg_loaded_r <= 1'b1;
         pll_out_divider_r <= cfg.pll_out_divider;
         pll_multiplier_r <= cfg.pll_multiplier;
         new_source_select_r <= cfg.new_source_select;
         secondary_osc_enable_r <= cfg.secondary_osc_enable;
      end else if (ctrl_wr) begin
         pll_out_divider_r <= reg_wdata[`OSCDC_PLL_OUT_DIV_HI:`OSCDC_PLL_OUT_DIV_LO];
         fast_rc_divider_r <= reg_wdata[`OSCDC_FAST_RC_DIV_HI:`OSCDC_FAST_RC_DIV_LO];
         pll_multiplier_r <= reg_wdata[`OSCDC_PLLMUL_HI:`OSCDC_PLLMUL_LO];
         new_source_select_r <= reg_wdata[`OSCDC_NEW_SRC_HI:`OSCDC_NEW_SRC_LO];
         secondary_osc_enable_r <= reg_wdata[`OSCDC_SOSC_EN_BIT];
      end
   end

   // Peripheral divisor accepts a write only while the ready flag is high.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         periph_clock_divisor_r <= `OSCDC_PB_DIV_RST;
      end else if (!cfg_loaded_r) begin
         periph_clock_divisor_r <= cfg.periph_clock_divisor;
      end else if (ctrl_wr && periph_divisor_ready) begin
         periph_clock_divisor_r <= wr_pb_field;
      end
   end

   // Divisor field of the write word, kept apart so that checks can look back on it.
   assign wr_pb_field = reg_wdata[`OSCDC_PB_DIV_HI:`OSCDC_PB_DIV_LO];

   // ****************************************************************
   // Dividers and monitors
   // ****************************************************************
   assign pll_shift = code_shift(pll_out_divider_r);
   assign fast_rc_shift = code_shift(fast_rc_divider_r);
   // Until the configuration loads, the divider is fed the configured code, so
   // it starts at that ratio and the ready flag stands high from the first access.
   assign pb_shift = cfg_loaded_r ? {2'h0, periph_clock_divisor_r} :
                     {2'h0, cfg.periph_clock_divisor};

   oscdc_pow2_div #(.SW(4)) u_pll_div (
      .mclk(mclk), .arst_n(arst_n), .shift(pll_shift),
      .tick(pll_div_tick), .settled()
   );
   oscdc_pow2_div #(.SW(4)) u_fast_rc_div (
      .mclk(mclk), .arst_n(arst_n), .shift(fast_rc_shift),
      .tick(fast_rc_div_tick), .settled()
   );
   oscdc_pow2_div #(.SW(4)) u_pb_div (
      .mclk(mclk), .arst_n(arst_n), .shift(pb_shift),
      .tick(periph_bus_clock_tick), .settled(pb_settled)
   );

   // Ready stays low while the new ratio waits for a period boundary.
   assign periph_divisor_ready = pb_settled && cfg_loaded_r;

   oscdc_sosc_mon #(.WARM(SOSC_WARM)) u_sosc (
      .mclk(mclk), .arst_n(arst_n), .enable(secondary_osc_enable_r),
      .ready(secondary_osc_ready)
   );

   assign pll_multiplier = pll_multiplier_r;
   assign new_source_select = new_source_select_r;
   assign secondary_osc_enable = secondary_osc_enable_r;

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Unlisted bits, unimplemented ones among them, stay zero.
   always_comb begin
      rd_word = 32'h0;
      rd_word[`OSCDC_PLL_OUT_DIV_HI:`OSCDC_PLL_OUT_DIV_LO] = pll_out_divider_r;
      rd_word[`OSCDC_FAST_RC_DIV_HI:`OSCDC_FAST_RC_DIV_LO] = fast_rc_divider_r;
      rd_word[`OSCDC_SOSC_READY_BIT] = secondary_osc_ready;
      rd_word[`OSCDC_PBRDY_BIT] = periph_divisor_ready;
      rd_word[`OSCDC_PB_DIV_HI:`OSCDC_PB_DIV_LO] = periph_clock_divisor_r;
      rd_word[`OSCDC_PLLMUL_HI:`OSCDC_PLLMUL_LO] = pll_multiplier_r;
      rd_word[`OSCDC_NEW_SRC_HI:`OSCDC_NEW_SRC_LO] = new_source_select_r;
      rd_word[`OSCDC_SOSC_EN_BIT] = secondary_osc_enable_r;
   end

   // Read data stands only in the cycle after the strobe; unmapped reads zero.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd && reg_addr == `OSCDC_ADDR_CTRL) begin
         reg_rdata <= rd_word;
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence unlock_seq;
      reg_wr && reg_addr == `OSCDC_ADDR_UNLOCK && reg_wdata == `OSCDC_KEY1 ##1
      reg_wr && reg_addr == `OSCDC_ADDR_UNLOCK && reg_wdata == `OSCDC_KEY2;
   endsequence

   locked_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (reg_wr && reg_addr == `OSCDC_ADDR_CTRL && lock_r != oscdc_pkg::OSCDC_OPEN && cfg_loaded_r)
      |=> $stable(fast_rc_divider_r))
      else $error("locked write changed the register");
   unlock_open_a: assert property (@(posedge mclk) disable iff (!arst_n)
      unlock_seq |=> lock_r == oscdc_pkg::OSCDC_OPEN)
      else $error("unlock sequence did not open");
   fast_rc_reset_a: assert property (@(posedge mclk)
      $rose(arst_n) |-> fast_rc_divider_r == `OSCDC_FAST_RC_DIV_RST)
      else $error("fast RC divider reset wrong");
   cfg_load_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !cfg_loaded_r |=> periph_clock_divisor_r == $past(cfg.periph_clock_divisor))
      else $error("configuration not loaded");
   pb_guard_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (!periph_divisor_ready && cfg_loaded_r) |=> $stable(periph_clock_divisor_r))
      else $error("divisor changed while not ready");
   pb_ready_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $changed(periph_clock_divisor_r) && cfg_loaded_r |-> ##[0:8] periph_divisor_ready)
      else $error("divisor ready did not return");
   reserved_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
      reg_rd |=> reg_rdata[31:30] == 2'h0 && !reg_rdata[23] && !reg_rdata[15] && !reg_rdata[11])
      else $error("reserved bit read as one");
   pb_tick_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (pb_settled && periph_clock_divisor_r == 2'h0) |-> periph_bus_clock_tick)
      else $error("divide by one did not tick");
   sosc_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !secondary_osc_enable_r |-> !secondary_osc_ready)
      else $error("ready while oscillator off");
   pll_256_a: assert property (@(posedge mclk) disable iff (!arst_n)
      pll_out_divider_r == 3'h7 |-> pll_shift == 4'h8)
      else $error("code 111 not divide by 256");
   fast_rc_64_a: assert property (@(posedge mclk) disable iff (!arst_n)
      fast_rc_divider_r == 3'h6 |-> fast_rc_shift == 4'h6)
      else $error("code 110 not divide by 64");
   pb_default_a: assert property (@(posedge mclk)
      $rose(arst_n) |-> periph_clock_divisor_r == `OSCDC_PB_DIV_RST)
      else $error("divisor reset not eight");
   relock_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (reg_wr && lock_r == oscdc_pkg::OSCDC_OPEN) |=> lock_r != oscdc_pkg::OSCDC_OPEN)
      else $error("register stayed open after a write");
   pb_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (ctrl_wr && periph_divisor_ready) |=> periph_clock_divisor_r == $past(wr_pb_field))
      else $error("divisor write while ready was lost");
endmodule : oscdc_ctrl

// ---- test/tb_oscillator_divider_control.sv ----
// Self-checking bench for the oscillator divider control register block.
// Assumes the design files and oscdc_params.svh are compiled before this file.
`include "oscdc_params.svh"

module tb_oscillator_divider_control;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Signals and design instance
   // ****************************************
   logic mclk, arst_n, reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, got;
   oscdc_pkg::oscdc_cfg_s cfg;
   logic pll_div_tick, fast_rc_div_tick, periph_bus_clock_tick;
   logic [2:0] pll_multiplier, new_source_select;
   logic secondary_osc_enable;
   logic [2:0] e_pll, e_fast, e_mul, e_src;
   logic [1:0] e_pb;
   logic e_sen, e_rdy;
   int miscompares, samples_checked;

   // A short warm-up keeps the ready flag reachable in a few cycles.
   oscdc_ctrl #(.SOSC_WARM(4)) i_dut (
      .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg(cfg),
      .pll_div_tick(pll_div_tick), .fast_rc_div_tick(fast_rc_div_tick),
      .periph_bus_clock_tick(periph_bus_clock_tick), .pll_multiplier(pll_multiplier),
      .new_source_select(new_source_select), .secondary_osc_enable(secondary_osc_enable)
   );

   // Clock of 4 ns period.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ****************************************
   // Bus tasks and helpers
   // ****************************************
   // Compare and count; a mismatch is reported at once.
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, g, e);
      end
   endtask : chk

   // One bus cycle; strobes are never cleared here so requests can run back to back.
   task automatic drv(input logic [3:0] a, input logic [31:0] d, input logic w, input logic r);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= r;
      @(posedge mclk);
   endtask : drv

   // Read of the control word; data stand only in the cycle after the strobe.
   task automatic rd();
      drv(`OSCDC_ADDR_CTRL, 32'h0, 1'b0, 1'b1);
      reg_rd <= 1'b0;
      #1;
      got = reg_rdata;
      @(posedge mclk);
   endtask : rd

   // Both keys and the control write go back to back, with no other write between.
   task automatic unlock_wr(input logic [31:0] d);
      drv(`OSCDC_ADDR_UNLOCK, `OSCDC_KEY1, 1'b1, 1'b0);
      drv(`OSCDC_ADDR_UNLOCK, `OSCDC_KEY2, 1'b1, 1'b0);
      drv(`OSCDC_ADDR_CTRL, d, 1'b1, 1'b0);
      drv(4'h0, 32'h0, 1'b0, 1'b0);
   endtask : unlock_wr

   // Poll the divisor ready flag with a bounded number of reads.
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         rd();
         n++;
      end while (got[21] !== 1'b1 && n < 20);
      chk({31'h0, got[21]}, 32'h1, "divisor ready after change");
   endtask : wait_ready

   function automatic logic tk(input int sel);
      return sel == 0 ? pll_div_tick : (sel == 1 ? fast_rc_div_tick : periph_bus_clock_tick);
   endfunction : tk

   function automatic int ratio(input logic [2:0] c);
      return c == 3'h7 ? 256 : (1 << c);
   endfunction : ratio

   // Expected readback; undocumented low fields read as zero in this design.
   function automatic logic [31:0] expw();
      return {2'h0, e_pll, e_fast, 1'b0, e_rdy, 1'b1, e_pb, e_mul, 5'h0, e_src, 6'h0,
              e_sen, 1'b0};
   endfunction : expw

   // Write word with reserved bits 31:30, 23, 15 and 11 set, so that a leak shows on readback.
   function automatic logic [31:0] cword();
      return {2'h3, e_pll, e_fast, 1'b1, 2'h0, e_pb, e_mul, 1'b1, 3'h0, 1'b1, e_src,
              6'h0, e_sen, 1'b0};
   endfunction : cword

   // Tick spacing; the first two intervals are skipped and only the third is checked, because a pending ratio change may lengthen the first.
   task automatic per(input int sel, input int exp, input string what);
      int n;
      n = 0;
      repeat (3) begin
         n = 0;
         do begin
            @(posedge mclk);
            #1;
            n++;
         end while (tk(sel) !== 1'b1 && n < 600);
      end
      chk(32'(n), 32'(exp), what);
      @(posedge mclk);
   endtask : per

   task automatic summarize();
      $display("Checks made: %0d, mismatches: %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   // ****************************************
   // Watchdog and test sequence
   // ****************************************
   // The tests need under 3,000 cycles; the limit of 50,000 cycles leaves ample margin.
   initial begin
      #200000;
      miscompares++;
      $display("Error at %0t ns: run did not finish", $time);
      summarize();
   end

   initial begin
      miscompares = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      cfg = '{3'h2, 2'h1, 3'h5, 3'h6, 1'b0};
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      {e_pll, e_pb, e_mul, e_src, e_sen} = {3'h2, 2'h1, 3'h5, 3'h6, 1'b0};
      e_fast = 3'h1;
      e_rdy = 1'b0;
      rd();
      chk(got, expw(), "word after reset");
      chk({26'h0, pll_multiplier, new_source_select}, {26'h0, e_mul, e_src}, "cfg outputs");
      // Plain write, then a key sequence with a wrong second key: both must be dropped.
      drv(`OSCDC_ADDR_CTRL, 32'h3fffffff, 1'b1, 1'b0);
      drv(`OSCDC_ADDR_UNLOCK, `OSCDC_KEY1, 1'b1, 1'b0);
      drv(`OSCDC_ADDR_UNLOCK, 32'h0, 1'b1, 1'b0);
      drv(`OSCDC_ADDR_CTRL, 32'h3fffffff, 1'b1, 1'b0);
      drv(4'h0, 32'h0, 1'b0, 1'b0);
      rd();
      chk(got, expw(), "locked writes ignored");
      // Every code of each divider field, with the tick spacing measured.
      for (int i = 0; i < 8; i++) begin
         e_pll = 3'(i);
         e_fast = 3'(7 - i);
         e_pb = 2'(i);
         e_mul = 3'(i);
         e_src = ~3'(i);
         unlock_wr(cword());
         wait_ready();
         chk(got, expw(), "word after unlocked write");
         chk({26'h0, pll_multiplier, new_source_select}, {26'h0, e_mul, e_src}, "outputs");
         per(0, ratio(e_pll), "post-pll tick spacing");
         per(1, ratio(e_fast), "fast rc tick spacing");
         per(2, 1 << e_pb, "peripheral tick spacing");
      end
      // Secondary oscillator enable, warm-up and switch-off.
      e_sen = 1'b1;
      unlock_wr(cword());
      repeat (12) @(posedge mclk);
      e_rdy = 1'b1;
      rd();
      chk(got, expw(), "oscillator ready after warm-up");
      chk({31'h0, secondary_osc_enable}, 32'h1, "oscillator enable output");
      e_sen = 1'b0;
      e_rdy = 1'b0;
      unlock_wr(cword());
      rd();
      chk(got, expw(), "oscillator ready after switch-off");
      // Second reset in mid-run with other configuration bits.
      arst_n <= 1'b0;
      cfg <= '{3'h7, 2'h3, 3'h1, 3'h4, 1'b1};
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      {e_pll, e_pb, e_mul, e_src, e_sen} = {3'h7, 2'h3, 3'h1, 3'h4, 1'b1};
      e_fast = 3'h1;
      rd();
      // The enable loads at the first edge, so the four-cycle warm-up is still running.
      chk(got, expw(), "word after second reset");
      summarize();
   end
endmodule : tb_oscillator_divider_control
